// ===== hw/bmu_top.v
`timescale 1ns/1ps
`include "bmu_defines.vh"
// Functional notes
// - Bit set forces the chosen bit to one, others unchanged.
// - Bit clear forces the chosen bit to zero, others unchanged.
// - Bit invert complements the chosen bit and writes the byte back.
// - Bit test loads zero flag with the complement of the chosen bit.
// - Bit AND stores carry AND chosen bit into the carry flag.
// - Bit position may come from a 3-bit immediate field.
// - Register-sourced position uses only the register's three low bits.
module bmu_top (
   input wire clk,
   input wire arst_n,
   input wire start,
   input wire [2:0] op,
   input wire use_mem,
   input wire pos_from_reg,
   input wire [2:0] imm_pos,
   input wire [7:0] pos_reg,
   input wire [7:0] reg_operand,
   input wire carry_in,
   input wire zero_in,
   input wire [15:0] mem_addr_in,
   input wire [7:0] mem_rdata,
   input wire mem_ack,
   output reg busy,
   output reg done,
   output reg reg_we,
   output reg [7:0] reg_wdata,
   output reg ccr_we,
   output reg carry_out,
   output reg zero_out,
   output reg mem_req,
   output reg mem_we,
   output reg [15:0] mem_addr,
   output reg [7:0] mem_wdata
);
   localparam ST_IDLE = 2'h0;
   localparam ST_READ = 2'h1;
   localparam ST_WRITE = 2'h2;
   reg rst_s1_q;
   reg rst_n_q;
   reg [1:0] state_q;
   reg [1:0] state_d;
   reg [2:0] op_q;
   reg [2:0] op_d;
   reg [2:0] pos_q;
   reg [2:0] pos_d;
   reg cin_q;
   reg cin_d;
   reg zin_q;
   reg zin_d;
   reg busy_d;
   reg done_d;
   reg reg_we_d;
   reg [7:0] reg_wdata_d;
   reg ccr_we_d;
   reg carry_d;
   reg zero_d;
   reg mem_req_d;
   reg mem_we_d;
   reg [15:0] mem_addr_d;
   reg [7:0] mem_wdata_d;
   wire [2:0] pos_sel;
   wire [7:0] alu_in;
   wire [2:0] alu_op;
   wire [2:0] alu_pos;
   wire alu_cin;
   wire alu_zin;
   wire [7:0] alu_res;
   wire alu_c;
   wire alu_z;
   wire alu_wb;

   // Phase decode shared by the op, position and flag muxes of the datapath; the operand mux tests ST_READ.
   function is_idle;
      input [1:0] st;
      begin
         is_idle = (st == ST_IDLE);
      end
   endfunction

   always @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         rst_s1_q <= 1'h0;
         rst_n_q <= 1'h0;
      end else begin
         rst_s1_q <= 1'h1;
         rst_n_q <= rst_s1_q;
      end
   end
   // Only the low three bits of a register index the byte.
   assign pos_sel = pos_from_reg ? pos_reg[2:0] : imm_pos;
   // In idle the register path works straight from the inputs so it finishes in one cycle.
   assign alu_in = (state_q == ST_READ) ? mem_rdata : reg_operand;
   // Once a memory operation runs, the captured request drives the datapath, so inputs may move on.
   assign alu_op = is_idle(state_q) ? op : op_q;
   assign alu_pos = is_idle(state_q) ? pos_sel : pos_q;
   assign alu_cin = is_idle(state_q) ? carry_in : cin_q;
   assign alu_zin = is_idle(state_q) ? zero_in : zin_q;
   bmu_bit_alu u_alu (
      .op(alu_op),
      .operand(alu_in),
      .bit_pos(alu_pos),
      .carry_in(alu_cin),
      .zero_in(alu_zin),
      .result(alu_res),
      .carry_out(alu_c),
      .zero_out(alu_z),
      .writes_back(alu_wb)
   );

   always @* begin
      state_d = state_q;
      op_d = op_q;
      pos_d = pos_q;
      cin_d = cin_q;
      zin_d = zin_q;
      busy_d = busy;
      done_d = 1'h0;
      reg_we_d = 1'h0;
      reg_wdata_d = reg_wdata;
      ccr_we_d = 1'h0;
      carry_d = carry_out;
      zero_d = zero_out;
      mem_req_d = mem_req;
      mem_we_d = mem_we;
      mem_addr_d = mem_addr;
      mem_wdata_d = mem_wdata;
      case (state_q)
         ST_IDLE: begin
            // A request is taken only in idle, so a start while busy is ignored.
            if (start) begin
               op_d = op;
               pos_d = pos_sel;
               cin_d = carry_in;
               zin_d = zero_in;
               if (use_mem) begin
                  mem_req_d = 1'h1;
                  mem_we_d = 1'h0;
                  mem_addr_d = mem_addr_in;
                  busy_d = 1'h1;
                  state_d = ST_READ;
               end else begin
                  reg_we_d = alu_wb;
                  reg_wdata_d = alu_res;
                  ccr_we_d = ~alu_wb;
                  carry_d = alu_c;
                  zero_d = alu_z;
                  done_d = 1'h1;
               end
            end
         end
         ST_READ: begin
            if (mem_ack) begin
               if (alu_wb) begin
                  // The request stays up, so the modified byte goes back to the same address.
                  mem_we_d = 1'h1;
                  mem_wdata_d = alu_res;
                  state_d = ST_WRITE;
               end else begin
                  mem_req_d = 1'h0;
                  ccr_we_d = 1'h1;
                  carry_d = alu_c;
                  zero_d = alu_z;
                  busy_d = 1'h0;
                  done_d = 1'h1;
                  state_d = ST_IDLE;
               end
            end
         end
         ST_WRITE: begin
            if (mem_ack) begin
               mem_req_d = 1'h0;
               mem_we_d = 1'h0;
               busy_d = 1'h0;
               done_d = 1'h1;
               state_d = ST_IDLE;
            end
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always @(posedge clk or negedge rst_n_q) begin
      if (!rst_n_q) begin
         state_q <= ST_IDLE;
         op_q <= 3'h0;
         pos_q <= 3'h0;
         cin_q <= 1'h0;
         zin_q <= 1'h0;
         busy <= 1'h0;
         done <= 1'h0;
         reg_we <= 1'h0;
         reg_wdata <= `BMU_RST_BYTE;
         ccr_we <= 1'h0;
         carry_out <= 1'h0;
         zero_out <= 1'h0;
         mem_req <= 1'h0;
         mem_we <= 1'h0;
         mem_addr <= `BMU_RST_ADDR;
         mem_wdata <= `BMU_RST_BYTE;
      end else begin
         state_q <= state_d;
         op_q <= op_d;
         pos_q <= pos_d;
         cin_q <= cin_d;
         zin_q <= zin_d;
         busy <= busy_d;
         done <= done_d;
         reg_we <= reg_we_d;
         reg_wdata <= reg_wdata_d;
         ccr_we <= ccr_we_d;
         carry_out <= carry_d;
         zero_out <= zero_d;
         mem_req <= mem_req_d;
         mem_we <= mem_we_d;
         mem_addr <= mem_addr_d;
         mem_wdata <= mem_wdata_d;
      end
   end
endmodule

// ===== hw/bmu_defines.vh
`ifndef BMU_DEFINES_VH
`define BMU_DEFINES_VH
`define BMU_OP_SET 3'h0
`define BMU_OP_CLR 3'h1
`define BMU_OP_INV 3'h2
`define BMU_OP_TST 3'h3
`define BMU_OP_AND 3'h4
`define BMU_RST_BYTE 8'h00
`define BMU_RST_ADDR 16'h0000
`endif

// ===== hw/bmu_bit_alu.v
`timescale 1ns/1ps
`include "bmu_defines.vh"
module bmu_bit_alu (
   input wire [2:0] op,
   input wire [7:0] operand,
   input wire [2:0] bit_pos,
   input wire carry_in,
   input wire zero_in,
   output reg [7:0] result,
   output reg carry_out,
   output reg zero_out,
   output reg writes_back
);
   wire [7:0] mask;
   wire sel_bit;
   assign mask = 8'h01 << bit_pos;
   assign sel_bit = operand[bit_pos];
   always @* begin
      result = operand;
      carry_out = carry_in;
      zero_out = zero_in;
      writes_back = 1'b0;
      case (op)
         `BMU_OP_SET: begin
            result = operand | mask;
            writes_back = 1'b1;
         end
         `BMU_OP_CLR: begin
            result = operand & ~mask;
            writes_back = 1'b1;
         end
         `BMU_OP_INV: begin
            result = operand ^ mask;
            writes_back = 1'b1;
         end
         `BMU_OP_TST: begin
            zero_out = ~sel_bit;
         end
         `BMU_OP_AND: begin
            carry_out = carry_in & sel_bit;
         end
         default: begin
            result = operand;
         end
      endcase
   end
endmodule

// ===== tb/bmu_mem_model.sv
`timescale 1ns/1ps
module bmu_mem_model (
   input wire clk,
   input wire mem_req,
   input wire mem_we,
   input wire [15:0] mem_addr,
   input wire [7:0] mem_wdata,
   input wire [3:0] wait_cyc,
   output logic mem_ack = 1'b0,
   output logic [7:0] mem_rdata = 8'h00
);
   logic [7:0] m [0:255];
   logic [3:0] n = 4'h0;
   // Idle data toggles so that a stale byte is never taken for a fresh one.
   always @(posedge clk) begin
      mem_rdata <= ~mem_rdata;
      mem_ack <= 1'b0;
      n <= mem_req && !mem_ack ? n + 4'h1 : 4'h0;
      if (mem_req && !mem_ack && n >= wait_cyc) begin
         mem_ack <= 1'b1;
         if (mem_we)
            m[mem_addr[7:0]] <= mem_wdata;
         else
            mem_rdata <= m[mem_addr[7:0]];
      end
   end
endmodule

// ===== tb/bmu_chk.sv
`timescale 1ns/1ps
module bmu_chk (
   input wire clk,
   input wire arst_n,
   input wire start,
   input wire use_mem,
   input wire pos_from_reg,
   input wire carry_in,
   input wire busy,
   input wire done,
   input wire reg_we,
   input wire ccr_we,
   input wire carry_out,
   input wire zero_out,
   input wire mem_we,
   input wire [2:0] op,
   input wire [2:0] imm_pos,
   input wire [7:0] pos_reg,
   input wire [7:0] reg_operand,
   input wire [7:0] reg_wdata
);
   wire [7:0] m = 8'h01 << (pos_from_reg ? pos_reg[2:0] : imm_pos);
   wire [7:0] d = reg_operand;
   wire [7:0] set_exp = d | m;
   wire [7:0] clr_exp = d & ~m;
   wire [7:0] inv_exp = d ^ m;
   wire zero_exp = ~|(d & m);
   wire carry_exp = carry_in & (|(d & m));
   wire g = start && !busy && !use_mem;
   wire h = start && !busy && use_mem;
   default clocking @(posedge clk); endclocking
   default disable iff (!arst_n);
   a_set_bit: assert property (g && op == 3'h0 |=> reg_we && reg_wdata == $past(set_exp)) else $error("set");
   a_clr_bit: assert property (g && op == 3'h1 |=> reg_wdata == $past(clr_exp)) else $error("clr");
   a_inv_bit: assert property (g && op == 3'h2 |=> reg_wdata == $past(inv_exp)) else $error("inv");
   a_test_zero: assert property (g && op == 3'h3 |=> ccr_we && zero_out == $past(zero_exp)) else $error("tst");
   a_and_carry: assert property (g && op == 3'h4 |=> carry_out == $past(carry_exp)) else $error("and");
   a_read_only: assert property (h && op > 3'h2 |=> !mem_we [*8]) else $error("ro");
   a_mem_write: assert property (h && op < 3'h3 |=> ##[1:40] mem_we) else $error("rmw");
   a_mem_done: assert property (h |=> busy ##[1:60] done) else $error("end");
   c_reg: cover property (g ##1 reg_we);
   c_read: cover property (h && op == 3'h3 ##1 busy);
   c_write: cover property (mem_we ##1 done);
endmodule
bind bmu_top bmu_chk chk (.*);

// ===== tb/test_bmu_top.sv
`timescale 1ns/1ps
module test_bmu_top;
   logic clk, arst_n, start, use_mem, pos_from_reg, carry_in, zero_in, mem_ack, busy, done;
   logic reg_we, ccr_we, carry_out, zero_out, mem_req, mem_we;
   logic [2:0] op, imm_pos;
   logic [3:0] wait_cyc;
   logic [7:0] pos_reg, reg_operand, mem_rdata, reg_wdata, mem_wdata, x;
   logic [15:0] mem_addr_in, mem_addr;
   integer errors = 0, samples_checked = 0, i;
   bmu_top dut (.*);
   bmu_mem_model mem (.*);
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   task chk(input [7:0] g, input [7:0] e);
      samples_checked++;
      if (g !== e) begin
         errors++;
         $display("wrong value at %0t: %h %h", $time, g, e);
      end
   endtask
   task end_sim;
      if (errors == 0 && samples_checked > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // The register view of the position is the inverse of the immediate one, so a wrong source shows.
   task go(input [2:0] o, input u, input r, input [7:0] p, input [7:0] d);
      @(posedge clk);
      {op, use_mem, pos_from_reg, reg_operand} <= {o, u, r, d};
      pos_reg <= r ? p : ~p;
      imm_pos <= r ? ~p[2:0] : p[2:0];
      start <= 1'b1;
      @(posedge clk);
      start <= 1'b0;
      #1;
      while (done !== 1'b1) begin
         @(posedge clk);
         #1;
      end
   endtask
   task t_reg;
      for (i = 0; i < 5; i++) begin
         x = 8'h02 << i;
         go(i[2:0], 1'b0, 1'b0, {5'h00, i[2:0] + 3'h1}, 8'hA5);
         if (i < 3) begin
            chk(reg_wdata, i == 0 ? 8'hA5 | x : i == 1 ? 8'hA5 & ~x : 8'hA5 ^ x);
            chk({6'h00, reg_we, ccr_we}, 8'h02);
         end else begin
            chk({4'h0, reg_we, ccr_we, zero_out, carry_out}, i == 3 ? 8'h07 : 8'h05);
         end
      end
      // A clear bit under a set carry shows whether the carry is really combined with the bit.
      go(3'h4, 1'b0, 1'b0, 8'h01, 8'hA5);
      chk({5'h00, ccr_we, zero_out, carry_out}, 8'h04);
      go(3'h1, 1'b0, 1'b1, 8'hFE, 8'hFF);
      chk(reg_wdata, 8'hBF);
   endtask
   task t_mem;
      mem.m[8'h12] = 8'h3C;
      wait_cyc = 4'h3;
      go(3'h2, 1'b1, 1'b0, 8'h00, 8'h00);
      chk(mem.m[8'h12], 8'h3D);
      wait_cyc = 4'h0;
      go(3'h3, 1'b1, 1'b0, 8'h02, 8'h00);
      chk({7'h00, zero_out}, 8'h00);
      chk(mem.m[8'h12], 8'h3D);
   endtask
   initial begin
      {arst_n, start, use_mem, pos_from_reg, carry_in, zero_in} = 6'h02;
      {op, imm_pos, pos_reg, reg_operand, wait_cyc} = 26'h0;
      mem_addr_in = 16'h0012;
      repeat (12) @(posedge clk);
      arst_n <= 1'b1;
      repeat (3) @(posedge clk);
      #1;
      t_reg;
      t_mem;
      end_sim;
   end
   initial begin
      #3000;
      errors++;
      end_sim;
   end
endmodule
